// ### rtl/clock_failure_monitor_monitor.sv
`timescale 1ns/1ns
module clock_failure_monitor_monitor #(
  parameter int unsigned STARTUP_CYCLES = clock_failure_monitor_pkg::STARTUP_CYCLES_DEF
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic [31:0]                  hrdata,
  input  wire clock_failure_monitor_pkg::clock_failure_monitor_cfg_t     cfg,
  input  wire logic                    ext_clk,
  input  wire logic                    lf_osc_clk,
  input  wire logic                    wake_req,
  output clock_failure_monitor_pkg::clock_failure_monitor_clk_sel_t      clk_sel,
  output logic                         osc_fail_irq,
  output logic                         fail_safe_active,
  output logic                         startup_running
);
  import clock_failure_monitor_pkg::*;

  // ==========================================================================
  // synchronisers and edge detection
  // ==========================================================================
  logic [2:0] ext_sync;
  logic [2:0] lf_sync;
  logic [2:0] next_ext_sync;
  logic [2:0] next_lf_sync;
  logic       ext_fall;
  logic       lf_rise;

  always_comb begin
    next_ext_sync = {ext_sync[1:0], ext_clk};
    next_lf_sync  = {lf_sync[1:0], lf_osc_clk};
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_sync <= 3'h0;
      lf_sync  <= 3'h0;
    end else begin
      ext_sync <= next_ext_sync;
      lf_sync  <= next_lf_sync;
    end
  end

  // only stages 1 and 2 feed logic
  assign ext_fall = ext_sync[2] & ~ext_sync[1];
  assign lf_rise  = ~lf_sync[2] & lf_sync[1];

  // ==========================================================================
  // bus address phase
  // ==========================================================================
  logic       wr_pend;
  logic [7:0] wr_addr;
  logic       next_wr_pend;
  logic [7:0] next_wr_addr;
  logic       take;
  logic       wr_switch;
  logic       wr_request;
  logic       wr_enable;
  logic       wr_sleep;

  assign take = hsel & htrans[1] & hready;

  always_comb begin
    next_wr_pend = take & hwrite;
    next_wr_addr = take ? haddr[7:0] : wr_addr;
  end

  assign wr_switch  = wr_pend & (wr_addr == ADDR_SWITCH);
  assign wr_request = wr_pend & (wr_addr == ADDR_REQUEST);
  assign wr_enable  = wr_pend & (wr_addr == ADDR_ENABLE);
  assign wr_sleep   = wr_pend & (wr_addr == ADDR_SLEEP) & hwdata[SLEEP_BIT];

  // ==========================================================================
  // sample clock and detector latch
  // ==========================================================================
  logic [SAMPLE_CNT_W-1:0] sample_cnt;
  logic                    sample_clk;
  logic                    det_latch;
  logic                    armed;
  logic [SAMPLE_CNT_W-1:0] next_sample_cnt;
  logic                    next_sample_clk;
  logic                    next_det_latch;
  logic                    next_armed;
  logic                    sample_rise;
  logic                    sample_fall;
  logic                    monitor_on;
  logic                    fail_evt;

  always_comb begin
    next_sample_cnt = sample_cnt;
    next_sample_clk = sample_clk;
    sample_rise     = 1'b0;
    sample_fall     = 1'b0;
    if (lf_rise) begin
      // toggle every half of the divide ratio
      if (sample_cnt == SAMPLE_CNT_W'(SAMPLE_HALF_EDGES - 1)) begin
        next_sample_cnt = '0;
        next_sample_clk = ~sample_clk;
        sample_rise     = ~sample_clk;
        sample_fall     = sample_clk;
      end else begin
        next_sample_cnt = sample_cnt + SAMPLE_CNT_W'(1);
      end
    end
    next_det_latch = det_latch;
    if (sample_rise) begin
      next_det_latch = 1'b0;
    end
    if (ext_fall) begin
      next_det_latch = 1'b1;
    end
    // arm only after a full clear, so a stale latch never trips
    next_armed = armed;
    if (!monitor_on) begin
      next_armed = 1'b0;
    end else if (sample_rise) begin
      next_armed = 1'b1;
    end
    fail_evt = monitor_on & armed & sample_fall & ~det_latch & ~ext_fall;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_cnt <= '0;
      sample_clk <= 1'b0;
      det_latch  <= 1'b0;
      armed      <= 1'b0;
    end else begin
      sample_cnt <= next_sample_cnt;
      sample_clk <= next_sample_clk;
      det_latch  <= next_det_latch;
      armed      <= next_armed;
    end
  end

  // ==========================================================================
  // clock control
  // ==========================================================================
  clock_failure_monitor_src_t                sel_src;
  logic [3:0]               sel_div;
  clock_failure_monitor_src_t                int_src;
  logic                     fail_safe;
  logic                     asleep;
  logic                     boot;
  logic                     timer_on;
  logic [STARTUP_CNT_W-1:0] timer_cnt;
  logic                     flag;
  logic                     irq_en;
  clock_failure_monitor_src_t                next_sel_src;
  logic [3:0]               next_sel_div;
  clock_failure_monitor_src_t                next_int_src;
  logic                     next_fail_safe;
  logic                     next_asleep;
  logic                     next_boot;
  logic                     next_timer_on;
  logic [STARTUP_CNT_W-1:0] next_timer_cnt;
  logic                     next_flag;
  logic                     next_irq_en;
  clock_failure_monitor_clk_sel_t            next_clk_sel;
  logic                     mode_ext;
  logic                     mode_clk_in;
  logic                     wants_ext;
  logic                     start_timer;

  always_comb begin
    mode_ext    = (cfg.mode != MODE_INTERNAL_ONLY) && (cfg.mode != MODE_RESERVED);
    mode_clk_in = (cfg.mode == MODE_EXT_CLOCK_HIGH) || (cfg.mode == MODE_EXT_CLOCK_MID) ||
                  (cfg.mode == MODE_EXT_CLOCK_LOW);
    wants_ext   = (sel_src == SRC_EXTERNAL) || (sel_src == SRC_EXTERNAL_PLL);
    monitor_on  = cfg.monitor_config_enable & mode_ext & wants_ext
                  & ~timer_on & ~fail_safe & ~asleep & ~boot;
  end

  always_comb begin
    next_sel_src   = sel_src;
    next_sel_div   = sel_div;
    next_int_src   = int_src;
    next_fail_safe = fail_safe;
    next_asleep    = asleep;
    next_boot      = 1'b0;
    next_timer_on  = timer_on;
    next_timer_cnt = timer_cnt;
    next_irq_en    = irq_en;
    start_timer    = 1'b0;

    // startup timer counts external cycles
    if (timer_on && ext_fall) begin
      if (timer_cnt == STARTUP_CNT_W'(STARTUP_CYCLES - 1)) begin
        next_timer_on = 1'b0;
      end else begin
        next_timer_cnt = timer_cnt + STARTUP_CNT_W'(1);
      end
    end

    if (boot) begin
      start_timer = wants_ext & mode_ext;
    end

    if (wr_switch) begin
      next_sel_src   = clock_failure_monitor_src_t'(hwdata[SRC_LSB +: 2]);
      next_sel_div   = hwdata[DIV_LSB +: 4];
      next_fail_safe = 1'b0;
      if ((next_sel_src == SRC_EXTERNAL) || (next_sel_src == SRC_EXTERNAL_PLL)) begin
        start_timer = mode_ext;
      end else begin
        next_int_src  = next_sel_src;
        next_timer_on = 1'b0;
      end
    end

    if (wr_sleep) begin
      next_asleep    = 1'b1;
      next_fail_safe = 1'b0;
      next_timer_on  = 1'b0;
    end else if (asleep && wake_req) begin
      next_asleep = 1'b0;
      start_timer = wants_ext & mode_ext;
    end

    if (start_timer && !mode_clk_in) begin
      next_timer_on  = 1'b1;
      next_timer_cnt = '0;
    end else if (start_timer) begin
      next_timer_on = 1'b0;
    end

    if (fail_evt) begin
      next_fail_safe = 1'b1;
    end

    if (wr_enable) begin
      next_irq_en = hwdata[IE_BIT];
    end

    // software write first, so a failure in the same cycle still sets it
    next_flag = flag;
    if (wr_request) begin
      next_flag = hwdata[FLAG_BIT];
    end
    if (fail_evt) begin
      next_flag = 1'b1;
    end

    if (next_fail_safe) begin
      next_clk_sel.src = SRC_HF_INTERNAL;
      next_clk_sel.div = DIV_FAILSAFE;
    end else if (next_timer_on || next_boot || boot) begin
      next_clk_sel.src = next_int_src;
      next_clk_sel.div = next_sel_div;
    end else begin
      next_clk_sel.src = next_sel_src;
      next_clk_sel.div = next_sel_div;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_src          <= RST_SRC;
      sel_div          <= RST_DIV;
      int_src          <= SRC_HF_INTERNAL;
      fail_safe        <= 1'b0;
      asleep           <= 1'b0;
      boot             <= 1'b1;
      timer_on         <= 1'b0;
      timer_cnt        <= '0;
      flag             <= 1'b0;
      irq_en           <= 1'b0;
      clk_sel          <= '{src: SRC_HF_INTERNAL, div: RST_DIV};
      osc_fail_irq     <= 1'b0;
      fail_safe_active <= 1'b0;
      startup_running  <= 1'b0;
    end else begin
      sel_src          <= next_sel_src;
      sel_div          <= next_sel_div;
      int_src          <= next_int_src;
      fail_safe        <= next_fail_safe;
      asleep           <= next_asleep;
      boot             <= next_boot;
      timer_on         <= next_timer_on;
      timer_cnt        <= next_timer_cnt;
      flag             <= next_flag;
      irq_en           <= next_irq_en;
      clk_sel          <= next_clk_sel;
      osc_fail_irq     <= next_flag & next_irq_en;
      fail_safe_active <= next_fail_safe;
      startup_running  <= next_timer_on;
    end
  end

  // ==========================================================================
  // bus read data and response
  // ==========================================================================
  logic [31:0] next_hrdata;

  always_comb begin
    next_hrdata = hrdata;
    if (take && !hwrite) begin
      next_hrdata = 32'h0000_0000;
      unique case (haddr[7:0])
        ADDR_SWITCH: begin
          next_hrdata[SRC_LSB +: 2] = next_sel_src;
          next_hrdata[DIV_LSB +: 4] = next_sel_div;
        end
        ADDR_REQUEST: begin
          next_hrdata[FLAG_BIT] = next_flag;
        end
        ADDR_ENABLE: begin
          next_hrdata[IE_BIT] = next_irq_en;
        end
        ADDR_STATUS: begin
          next_hrdata[ST_FAILSAFE]     = next_fail_safe;
          next_hrdata[ST_STARTUP]      = next_timer_on;
          next_hrdata[ST_ASLEEP]       = next_asleep;
          next_hrdata[ST_MONITOR]      = monitor_on;
          next_hrdata[ST_RUN_SRC +: 2] = next_clk_sel.src;
          next_hrdata[ST_RUN_DIV +: 4] = next_clk_sel.div;
        end
        ADDR_SLEEP: begin
          next_hrdata[SLEEP_BIT] = next_asleep;
        end
        default: begin
          next_hrdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      wr_pend   <= next_wr_pend;
      wr_addr   <= next_wr_addr;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule

// ### shared/clock_failure_monitor_pkg.sv
package clock_failure_monitor_pkg;

  // ==========================================================================
  // clocking and timing
  // ==========================================================================
  localparam int unsigned SYS_CLK_HZ         = 100_000_000;
  localparam int unsigned SAMPLE_DIVIDE      = 64;
  localparam int unsigned SAMPLE_HALF_EDGES  = SAMPLE_DIVIDE / 2;
  localparam int unsigned STARTUP_CYCLES_DEF = 1024;
  localparam int unsigned STARTUP_CNT_W      = 16;
  localparam int unsigned SAMPLE_CNT_W       = 5;

  // ==========================================================================
  // register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] ADDR_SWITCH  = 8'h00;
  localparam logic [7:0] ADDR_REQUEST = 8'h04;
  localparam logic [7:0] ADDR_ENABLE  = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0C;
  localparam logic [7:0] ADDR_SLEEP   = 8'h10;

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int unsigned SRC_LSB      = 0;
  localparam int unsigned DIV_LSB      = 4;
  localparam int unsigned FLAG_BIT     = 0;
  localparam int unsigned IE_BIT       = 0;
  localparam int unsigned SLEEP_BIT    = 0;
  localparam int unsigned ST_FAILSAFE  = 0;
  localparam int unsigned ST_STARTUP   = 1;
  localparam int unsigned ST_ASLEEP    = 2;
  localparam int unsigned ST_MONITOR   = 3;
  localparam int unsigned ST_RUN_SRC   = 4;
  localparam int unsigned ST_RUN_DIV   = 8;

  // ==========================================================================
  // encodings and reset values
  // ==========================================================================
  typedef enum logic [1:0] {
    SRC_HF_INTERNAL = 2'h0,
    SRC_LF_INTERNAL = 2'h1,
    SRC_EXTERNAL    = 2'h2,
    SRC_EXTERNAL_PLL = 2'h3
  } clock_failure_monitor_src_t;

  typedef enum logic [2:0] {
    MODE_EXT_CLOCK_HIGH   = 3'h0,
    MODE_EXT_CLOCK_MID    = 3'h1,
    MODE_EXT_CLOCK_LOW    = 3'h2,
    MODE_INTERNAL_ONLY    = 3'h3,
    MODE_LOW_POWER_XTAL   = 3'h4,
    MODE_CRYSTAL          = 3'h5,
    MODE_HIGH_SPEED_XTAL  = 3'h6,
    MODE_RESERVED         = 3'h7
  } clock_failure_monitor_mode_t;

  localparam clock_failure_monitor_src_t  RST_SRC      = SRC_EXTERNAL;
  localparam logic [3:0] RST_DIV      = 4'h0;
  // divider code that gives 1 MHz from the high-frequency internal oscillator
  localparam logic [3:0] DIV_FAILSAFE = 4'h5;

  typedef struct packed {
    logic       monitor_config_enable;
    clock_failure_monitor_mode_t mode;
  } clock_failure_monitor_cfg_t;

  typedef struct packed {
    clock_failure_monitor_src_t  src;
    logic [3:0] div;
  } clock_failure_monitor_clk_sel_t;

endpackage

// ### sim/clock_failure_monitor_osc_model.sv
`timescale 1ns/1ns
// ==========================================================================
// external oscillator
// ==========================================================================
module clock_failure_monitor_osc_model #(
  parameter int HALF_NS = 25
) (
  input  wire logic run,
  output logic      ext_clk
);
  // a dead oscillator sits high, so no falling edge reaches the latch
  initial ext_clk = 1'b1;
  always begin
    #(HALF_NS);
    ext_clk = run ? ~ext_clk : 1'b1;
  end
endmodule

// ### sim/clock_failure_monitor_monitor_chk.sv
`timescale 1ns/1ns
// ==========================================================================
// port checker
// ==========================================================================
module clock_failure_monitor_monitor_chk (
  input wire logic                    sys_clk,
  input wire logic                    rst_n,
  input wire logic                    hsel,
  input wire logic [31:0]             haddr,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic                    hready,
  input wire logic                    hreadyout,
  input wire logic                    hresp,
  input wire clock_failure_monitor_pkg::clock_failure_monitor_cfg_t     cfg,
  input wire clock_failure_monitor_pkg::clock_failure_monitor_clk_sel_t clk_sel,
  input wire logic                    osc_fail_irq,
  input wire logic                    fail_safe_active,
  input wire logic                    startup_running
);
  import clock_failure_monitor_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic taken;
  logic next_sw_wr;
  logic next_reg_wr;
  logic sw_wr;
  logic reg_wr;
  always_comb begin
    taken       = hsel && htrans[1] && hready && hwrite;
    next_sw_wr  = taken && haddr[7:0] == ADDR_SWITCH;
    next_reg_wr = taken && (haddr[7:0] == ADDR_REQUEST || haddr[7:0] == ADDR_ENABLE);
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_wr  <= 1'b0;
      reg_wr <= 1'b0;
    end else begin
      sw_wr  <= next_sw_wr;
      reg_wr <= next_reg_wr;
    end
  end
  okay_resp_a: assert property (hresp == 1'b0) else $error("bus response not okay");
  ready_high_a: assert property ($past(rst_n) |-> hreadyout) else $error("hreadyout low");
  failsafe_sel_a: assert property ($rose(fail_safe_active) |->
    clk_sel == {SRC_HF_INTERNAL, DIV_FAILSAFE}) else $error("fail-safe select wrong");
  after_timer_a: assert property ($rose(fail_safe_active) |->
    !$past(startup_running)) else $error("failure seen while timer ran");
  cfg_gate_a: assert property ($rose(fail_safe_active) |->
    cfg.monitor_config_enable) else $error("failure with monitor disabled");
  mode_gate_a: assert property ($rose(fail_safe_active) |->
    cfg.mode != MODE_INTERNAL_ONLY) else $error("failure in internal mode");
  timer_internal_a: assert property (startup_running |->
    clk_sel.src inside {SRC_HF_INTERNAL, SRC_LF_INTERNAL}) else $error("timer on external");
  ec_no_timer_a: assert property (cfg.mode inside {MODE_EXT_CLOCK_HIGH,
    MODE_EXT_CLOCK_MID, MODE_EXT_CLOCK_LOW} |-> !startup_running) else $error("timer in ec");
  switch_clear_a: assert property (sw_wr |=> !fail_safe_active)
    else $error("switch left fail-safe");
  irq_rise_a: assert property ($rose(osc_fail_irq) |-> $rose(fail_safe_active)
    || $past(reg_wr) || $past(reg_wr, 2)) else $error("irq rose without cause");
  irq_fall_a: assert property ($fell(osc_fail_irq) |->
    $past(reg_wr) || $past(reg_wr, 2)) else $error("irq fell without write");
  cover property ($rose(fail_safe_active));
  cover property ($fell(startup_running));
  cover property (sw_wr);
  cover property ($fell(osc_fail_irq));
endmodule

bind clock_failure_monitor_monitor clock_failure_monitor_monitor_chk clock_failure_monitor_monitor_chk_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .cfg(cfg),
  .clk_sel(clk_sel), .osc_fail_irq(osc_fail_irq), .fail_safe_active(fail_safe_active),
  .startup_running(startup_running)
);

// ### sim/clock_failure_monitor_monitor_bench.sv
`timescale 1ns/1ns
// ==========================================================================
// bench
// ==========================================================================
module clock_failure_monitor_monitor_bench;
  import clock_failure_monitor_pkg::*;
  localparam clock_failure_monitor_mode_t MODES [6] = '{MODE_LOW_POWER_XTAL, MODE_CRYSTAL,
    MODE_HIGH_SPEED_XTAL, MODE_EXT_CLOCK_LOW, MODE_EXT_CLOCK_MID, MODE_EXT_CLOCK_HIGH};
  logic          sys_clk, rst_n, hsel, hwrite, wake_req, lf_osc_clk, osc_run;
  logic          hreadyout, hresp, osc_fail_irq, fail_safe_active, startup_running;
  logic          ext_clk;
  logic [31:0]   haddr, hwdata, hrdata, rd;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  clock_failure_monitor_cfg_t     cfg;
  clock_failure_monitor_clk_sel_t clk_sel;
  int            n_errors, samples_checked;

  always #5 sys_clk = ~sys_clk;
  always #40 lf_osc_clk = ~lf_osc_clk;

  clock_failure_monitor_monitor #(.STARTUP_CYCLES(4)) clock_failure_monitor_monitor_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cfg(cfg), .ext_clk(ext_clk),
    .lf_osc_clk(lf_osc_clk), .wake_req(wake_req), .clk_sel(clk_sel),
    .osc_fail_irq(osc_fail_irq), .fail_safe_active(fail_safe_active),
    .startup_running(startup_running)
  );
  clock_failure_monitor_osc_model clock_failure_monitor_osc_model_inst (.run(osc_run), .ext_clk(ext_clk));

  task wrap_up;
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task check_bit(input string nm, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task check_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task do_reset(input clock_failure_monitor_cfg_t c);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    cfg   <= c;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    #1;
  endtask

  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 100);
    rd = hrdata;
    #1;
    if (n >= 100) begin
      n_errors++;
      $display("[ERR] hready expected 1 seen 0");
      wrap_up;
    end
  endtask

  // w 0 watches fail_safe_active, w 1 watches startup_running
  task wait_lvl(input int w, input logic v, input int lim, output int n);
    n = 0;
    while ((w ? startup_running : fail_safe_active) !== v && n < lim) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if ((w ? startup_running : fail_safe_active) !== v) begin
      n_errors++;
      $display("[ERR] wait %0d expected %b seen %b", w, v, ~v);
      wrap_up;
    end
  endtask

  task t_boot;
    int n;
    wait_lvl(1, 1'b1, 5, n);
    wait_lvl(1, 1'b0, 200, n);
    check_word("run select", {26'h0, SRC_EXTERNAL, RST_DIV}, {26'h0, clk_sel});
    check_bit("hresp", 1'b0, hresp);
    ahb(1'b1, ADDR_ENABLE, 32'h1);
    ahb(1'b0, ADDR_ENABLE, 32'h0);
    check_word("enable", 32'h1, rd);
    ahb(1'b0, 8'h40, 32'h0);
    check_word("unmapped", 32'h0, rd);
    $display("test boot done");
  endtask

  task t_fail;
    int n;
    osc_run = 1'b0;
    wait_lvl(0, 1'b1, 1200, n);
    check_bit("fail delay", 1'b1, n >= 240);
    check_word("fail select", {26'h0, SRC_HF_INTERNAL, DIV_FAILSAFE}, {26'h0, clk_sel});
    check_bit("irq", 1'b1, osc_fail_irq);
    ahb(1'b0, ADDR_REQUEST, 32'h0);
    check_word("flag", 32'h1, rd);
    ahb(1'b1, ADDR_ENABLE, 32'h0);
    check_bit("irq masked", 1'b0, osc_fail_irq);
    ahb(1'b0, ADDR_REQUEST, 32'h0);
    check_word("flag held", 32'h1, rd);
    check_bit("still safe", 1'b1, fail_safe_active);
    ahb(1'b1, ADDR_ENABLE, 32'h1);
    check_bit("irq back", 1'b1, osc_fail_irq);
    $display("test fail done");
  endtask

  task t_switch;
    int n;
    osc_run = 1'b1;
    ahb(1'b1, ADDR_REQUEST, 32'h0);
    check_bit("irq cleared", 1'b0, osc_fail_irq);
    ahb(1'b1, ADDR_SWITCH, 32'h32);
    check_bit("safe cleared", 1'b0, fail_safe_active);
    check_bit("timer on", 1'b1, startup_running);
    check_word("timer src", {30'h0, SRC_HF_INTERNAL}, {30'h0, clk_sel.src});
    ahb(1'b0, ADDR_REQUEST, 32'h0);
    check_word("busy read", 32'h0, rd);
    // timer running, internal source, new divider 3 in status
    ahb(1'b0, ADDR_STATUS, 32'h0);
    check_word("status", 32'h0000_0302, rd);
    wait_lvl(1, 1'b0, 200, n);
    check_word("ext select", {26'h0, SRC_EXTERNAL, 4'h3}, {26'h0, clk_sel});
    ahb(1'b0, ADDR_SWITCH, 32'h0);
    check_word("switch read", 32'h0000_0032, rd);
    $display("test switch done");
  endtask

  task t_refail;
    int n;
    osc_run = 1'b0;
    wait_lvl(0, 1'b1, 1200, n);
    ahb(1'b0, ADDR_REQUEST, 32'h0);
    check_word("flag again", 32'h1, rd);
    check_bit("irq again", 1'b1, osc_fail_irq);
    ahb(1'b1, ADDR_SLEEP, 32'h1);
    check_bit("sleep clears", 1'b0, fail_safe_active);
    osc_run = 1'b1;
    @(posedge sys_clk);
    wake_req <= 1'b1;
    @(posedge sys_clk);
    wake_req <= 1'b0;
    #1;
    wait_lvl(1, 1'b1, 5, n);
    wait_lvl(1, 1'b0, 200, n);
    ahb(1'b0, ADDR_SLEEP, 32'h0);
    check_word("awake", 32'h0, rd);
    $display("test refail and sleep done");
  endtask

  task t_cfg_off;
    int n;
    do_reset('{1'b0, MODE_CRYSTAL});
    wait_lvl(1, 1'b0, 200, n);
    // park on the slow internal source, then go external through the pll
    ahb(1'b1, ADDR_SWITCH, 32'h1);
    check_word("lf select", {26'h0, SRC_LF_INTERNAL, 4'h0}, {26'h0, clk_sel});
    ahb(1'b1, ADDR_SWITCH, 32'h3);
    check_bit("pll timer", 1'b1, startup_running);
    check_word("pll timer src", {30'h0, SRC_LF_INTERNAL}, {30'h0, clk_sel.src});
    wait_lvl(1, 1'b0, 200, n);
    check_word("pll select", {26'h0, SRC_EXTERNAL_PLL, 4'h0}, {26'h0, clk_sel});
    osc_run = 1'b0;
    repeat (1200) @(posedge sys_clk);
    #1;
    check_bit("no monitor", 1'b0, fail_safe_active);
    osc_run = 1'b1;
    $display("test disabled done");
  endtask

  task t_modes;
    int n;
    for (int i = 0; i < 6; i++) begin
      do_reset('{1'b1, MODES[i]});
      repeat (3) @(posedge sys_clk);
      #1;
      if (i > 2) check_bit("ec timer", 1'b0, startup_running);
      wait_lvl(1, 1'b0, 200, n);
      osc_run = 1'b0;
      wait_lvl(0, 1'b1, 1200, n);
      check_word("mode select", {26'h0, SRC_HF_INTERNAL, DIV_FAILSAFE}, {26'h0, clk_sel});
      osc_run = 1'b1;
    end
    $display("test modes done");
  endtask

  initial begin
    sys_clk = 1'b0;
    lf_osc_clk = 1'b0;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    wake_req = 1'b0;
    osc_run = 1'b1;
    cfg = '{1'b1, MODE_CRYSTAL};
    n_errors = 0;
    samples_checked = 0;
    do_reset('{1'b1, MODE_CRYSTAL});
    t_boot;
    t_fail;
    t_switch;
    t_refail;
    t_cfg_off;
    t_modes;
    wrap_up;
  end
endmodule
